// >>> logic/rci_regs.svh
// Purpose: named constants of the remote control input decoder
// Assumes: one 250 MHz system clock
// Notes: definitions only
`ifndef RCI_REGS_SVH
`define RCI_REGS_SVH

`define RCI_NUM_IN 10
`define RCI_IDX_W 4
`define RCI_ARG_W 4
`define RCI_VLD_W 3
`define RCI_CLK_MHZ 250
`define RCI_STEP_MS 500
`define RCI_STEP_CYC (`RCI_STEP_MS * 1000 * `RCI_CLK_MHZ)
`define RCI_TMR_W 27
`define RCI_EXC_A 4'h0
`define RCI_EXC_B 4'h1
`define RCI_PRESET_RST 4'h0
`define RCI_EXC_SEL_RST 1'b0
`define RCI_CHG_EN_RST 1'b0
`define RCI_DEF_RF_ON 4'h0
`define RCI_DEF_RF_OFF 4'h1
`define RCI_DEF_EXC_A 4'h2
`define RCI_DEF_EXC_B 4'h3
`define RCI_DEF_CHG 4'h4
`define RCI_DEF_PWR_UP 4'h5
`define RCI_DEF_PWR_DN 4'h6

`endif

// >>> logic/rci_pkg.sv
// Purpose: types shared by the remote control input decoder
// Assumes: rci_regs.svh holds the numbers
// Notes: default input map lives here as a constant function
`include "rci_regs.svh"

package rci_pkg;

  typedef enum logic [3:0] {
    RCI_FN_NONE, RCI_FN_RF, RCI_FN_RESET, RCI_FN_REBOOT,
    RCI_FN_EXC, RCI_FN_CHG, RCI_FN_PWR, RCI_FN_PRESET
  } rci_func_t;

  typedef enum logic [3:0] {
    RCI_MD_RISE_ON, RCI_MD_FALL_ON, RCI_MD_RISE_OFF, RCI_MD_FALL_OFF,
    RCI_MD_FALL_TOG, RCI_MD_RISE_TOG, RCI_MD_RISE_ON_FALL_OFF,
    RCI_MD_FALL_ON_RISE_OFF, RCI_MD_HI_INC, RCI_MD_LO_INC,
    RCI_MD_HI_DEC, RCI_MD_LO_DEC
  } rci_mode_t;

  typedef struct packed {
    rci_func_t func;
    rci_mode_t mode;
    logic [`RCI_ARG_W-1:0] arg;
  } rci_cfg_t;

  typedef struct packed {
    logic level;
    rci_cfg_t cfg;
  } rci_status_t;

  typedef struct packed {
    logic rf_on;
    logic rf_off;
    logic sys_reset;
    logic ui_reboot;
    logic exc_sel;
    logic chg_flip;
    logic power_up;
    logic power_dn;
    logic preset_sel;
  } rci_req_t;

  function automatic rci_cfg_t rci_default_cfg(input logic [`RCI_IDX_W-1:0] idx);
    rci_cfg_t c;
    c = '{func: RCI_FN_NONE, mode: RCI_MD_FALL_ON, arg: `RCI_EXC_A};
    case (idx)
      `RCI_DEF_RF_ON: c.func = RCI_FN_RF;
      `RCI_DEF_RF_OFF: c = '{func: RCI_FN_RF, mode: RCI_MD_FALL_OFF, arg: `RCI_EXC_A};
      `RCI_DEF_EXC_A: c.func = RCI_FN_EXC;
      `RCI_DEF_EXC_B: c = '{func: RCI_FN_EXC, mode: RCI_MD_FALL_ON, arg: `RCI_EXC_B};
      `RCI_DEF_CHG: c = '{func: RCI_FN_CHG, mode: RCI_MD_FALL_TOG, arg: `RCI_EXC_A};
      `RCI_DEF_PWR_UP: c = '{func: RCI_FN_PWR, mode: RCI_MD_LO_INC, arg: `RCI_EXC_A};
      `RCI_DEF_PWR_DN: c = '{func: RCI_FN_PWR, mode: RCI_MD_LO_DEC, arg: `RCI_EXC_A};
      default: c.func = RCI_FN_NONE;
    endcase
    return c;
  endfunction

endpackage

// >>> logic/rci_in_cond.sv
// Purpose: synchronise one remote input and turn it into activate events
// Assumes: pin may change at any time relative to ref_clk
// Notes: edges are suppressed until the sync chain holds real samples
`timescale 1ns/1ps
`include "rci_regs.svh"

module rci_in_cond import rci_pkg::*; (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // sync reset, high
  input wire logic din, // raw remote pin
  input wire logic en, // remote control state
  input wire rci_mode_t mode, // polarity mode
  output logic lvl, // synchronised level
  output logic act, // activate pulse
  output logic deact, // deactivate pulse
  output logic held, // held at active level
  output logic dec // mode is a decrease or turn-off variant
);
  logic s1_ff, s2_ff, prv_ff, tog_ff;
  logic [`RCI_VLD_W-1:0] vld_ff;
  logic vld, rise, fall, pol_hi, on_edge, off_edge, tog, is_off, two, tog_act;
  logic act_raw, deact_raw;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      prv_ff <= 1'b0;
      vld_ff <= '0;
      tog_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      prv_ff <= s2_ff;
      vld_ff <= {vld_ff[`RCI_VLD_W-2:0], 1'b1};
      if (en && tog && on_edge) begin
        tog_ff <= ~tog_ff;
      end
    end
  end

  assign vld = vld_ff[`RCI_VLD_W-1];
  assign rise = vld & s2_ff & ~prv_ff;
  assign fall = vld & ~s2_ff & prv_ff;
  assign pol_hi = (mode == RCI_MD_RISE_ON) || (mode == RCI_MD_RISE_OFF) ||
    (mode == RCI_MD_RISE_TOG) || (mode == RCI_MD_RISE_ON_FALL_OFF) ||
    (mode == RCI_MD_HI_INC) || (mode == RCI_MD_HI_DEC);
  assign on_edge = pol_hi ? rise : fall;
  assign off_edge = pol_hi ? fall : rise;
  assign tog = (mode == RCI_MD_RISE_TOG) || (mode == RCI_MD_FALL_TOG);
  assign is_off = (mode == RCI_MD_RISE_OFF) || (mode == RCI_MD_FALL_OFF);
  assign two = (mode == RCI_MD_RISE_ON_FALL_OFF) || (mode == RCI_MD_FALL_ON_RISE_OFF);
  // falling toggle starts by deactivating, rising toggle by activating
  assign tog_act = (tog_ff == (mode == RCI_MD_FALL_TOG));
  assign act_raw = tog ? (on_edge & tog_act) : (~is_off & on_edge);
  assign deact_raw = tog ? (on_edge & ~tog_act) : is_off ? on_edge :
    (two & off_edge);
  assign act = en & act_raw;
  assign deact = en & deact_raw;
  assign held = en & vld & (pol_hi ? s2_ff : ~s2_ff);
  assign dec = (mode == RCI_MD_HI_DEC) || (mode == RCI_MD_LO_DEC) || is_off;
  assign lvl = s2_ff;

endmodule

// >>> logic/rci_tick.sv
// Purpose: repeat timer for held power step inputs
// Assumes: restart held whenever no step input is being obeyed
// Notes: tick comes one full period after the restart is released
`timescale 1ns/1ps
`include "rci_regs.svh"

module rci_tick import rci_pkg::*; #(
  parameter int unsigned PERIOD = `RCI_STEP_CYC
) (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // sync reset, high
  input wire logic restart, // clear and hold the count
  output logic tick // one-cycle repeat pulse
);
  localparam logic [`RCI_TMR_W-1:0] LAST = `RCI_TMR_W'(PERIOD - 1);
  logic [`RCI_TMR_W-1:0] cnt_ff, nxt_cnt;

  assign tick = ~restart & (cnt_ff == LAST);
  assign nxt_cnt = (restart || tick) ? '0 : cnt_ff + `RCI_TMR_W'(1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// >>> logic/rci_decoder.sv
// Purpose: remote control input decoder, ten parallel control inputs
// Assumes: remote_mode comes from the local operator control only
// Notes: requests are registered one-cycle pulses; config held here
//
// Contract
// - ten inputs, own function and polarity
// - inputs ignored while in local control
// - remote/local state changed only locally
// - unassigned input never affects anything
// - rf input issues on or off request
// - reset input issues system reset
// - reboot input resets operator interface processor
// - exciter input selects A or B
// - changeover input inverts state per activation
// - power input steps one percent
// - held power input repeats every half second
// - lowest-numbered power input wins
// - preset input makes its preset active
// - default rf on and off, falling edges
// - rising turn-on mode activates on high
// - falling turn-on mode activates on low
// - turn-off modes deactivate on chosen edge
// - toggle modes alternate, order per polarity
// - two-edge modes: one activates, other deactivates
// - level modes act while held active
// - input level readable with its settings
`timescale 1ns/1ps
`include "rci_regs.svh"

module rci_decoder import rci_pkg::*; #(
  parameter int unsigned STEP_CYC = `RCI_STEP_CYC
) (
  input wire logic ref_clk, // 250 MHz system clock
  input wire logic sys_rst, // sync reset, high
  input wire logic [`RCI_NUM_IN-1:0] remote_in, // remote pins
  input wire logic remote_mode, // 1 remote, 0 local
  input wire logic cfg_wr_en, // config write strobe
  input wire logic [`RCI_IDX_W-1:0] cfg_wr_idx, // input to configure
  input wire rci_cfg_t cfg_wr_data, // function, mode, argument
  input wire logic [`RCI_IDX_W-1:0] stat_rd_idx, // input to report
  output rci_status_t stat_rd_data, // level and settings, registered
  output rci_req_t req, // request pulses, registered
  output logic exciter_sel_b, // main exciter is B
  output logic changeover_en, // auto changeover enabled
  output logic [`RCI_ARG_W-1:0] preset_sel // chosen preset
);

  rci_cfg_t cfg_ff [`RCI_NUM_IN];
  rci_status_t stat_ff;
  rci_req_t req_ff, nxt_req;
  logic exc_b_ff, nxt_exc_b;
  logic chg_ff, nxt_chg;
  logic [`RCI_ARG_W-1:0] preset_ff, nxt_preset;
  logic pwr_vld_ff;
  logic [`RCI_IDX_W-1:0] pwr_idx_ff;

  logic [`RCI_NUM_IN-1:0] lvl, act, deact, held, dec;
  logic [`RCI_NUM_IN-1:0] rf_on_v, rf_off_v, rst_v, boot_v;
  logic [`RCI_NUM_IN-1:0] exc_v, chg_v, pwr_v, pre_v;

  logic exc_hit, pre_hit, pwr_hit;
  logic [`RCI_IDX_W-1:0] exc_idx, pre_idx, pwr_idx;
  logic new_win, tick, step, step_dn;
  logic wr_ok, rd_ok;

  // lowest set bit wins; index meaningless when none set
  function automatic logic [`RCI_IDX_W-1:0] lowest(input logic [`RCI_NUM_IN-1:0] v);
    logic [`RCI_IDX_W-1:0] r;
    r = '0;
    for (int k = `RCI_NUM_IN - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = `RCI_IDX_W'(k);
      end
    end
    return r;
  endfunction

  // per-input conditioning and function decode
  genvar gi;
  generate
    for (gi = 0; gi < `RCI_NUM_IN; gi++) begin : g_in
      // remote_mode is only an input here, nothing can write it
      rci_in_cond u_cond (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .din(remote_in[gi]),
        .en(remote_mode),
        .mode(cfg_ff[gi].mode),
        .lvl(lvl[gi]),
        .act(act[gi]),
        .deact(deact[gi]),
        .held(held[gi]),
        .dec(dec[gi])
      );

      // RCI_FN_NONE matches none of these, so it decodes to nothing
      assign rf_on_v[gi] = act[gi] & (cfg_ff[gi].func == RCI_FN_RF);
      assign rf_off_v[gi] = deact[gi] & (cfg_ff[gi].func == RCI_FN_RF);
      assign rst_v[gi] = act[gi] & (cfg_ff[gi].func == RCI_FN_RESET);
      assign boot_v[gi] = act[gi] & (cfg_ff[gi].func == RCI_FN_REBOOT);
      assign exc_v[gi] = act[gi] & (cfg_ff[gi].func == RCI_FN_EXC);
      assign chg_v[gi] = act[gi] & (cfg_ff[gi].func == RCI_FN_CHG);
      assign pwr_v[gi] = held[gi] & (cfg_ff[gi].func == RCI_FN_PWR);
      assign pre_v[gi] = act[gi] & (cfg_ff[gi].func == RCI_FN_PRESET);

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          cfg_ff[gi] <= rci_default_cfg(`RCI_IDX_W'(gi));
        end else if (wr_ok && (cfg_wr_idx == `RCI_IDX_W'(gi))) begin
          cfg_ff[gi] <= cfg_wr_data;
        end
      end
    end
  endgenerate

  assign wr_ok = cfg_wr_en && (cfg_wr_idx < `RCI_IDX_W'(`RCI_NUM_IN));
  assign rd_ok = stat_rd_idx < `RCI_IDX_W'(`RCI_NUM_IN);

  // single-valued targets: lowest-numbered input settles a tie
  assign exc_hit = |exc_v;
  assign exc_idx = lowest(exc_v);
  assign pre_hit = |pre_v;
  assign pre_idx = lowest(pre_v);

  // power stepping: only the lowest held input is obeyed
  assign pwr_hit = |pwr_v;
  assign pwr_idx = lowest(pwr_v);
  assign new_win = pwr_hit & (~pwr_vld_ff | (pwr_idx != pwr_idx_ff));
  assign step = new_win | (pwr_hit & tick);
  assign step_dn = dec[pwr_idx];

  // a change of winner restarts the half-second spacing
  rci_tick #(
    .PERIOD(STEP_CYC)
  ) u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .restart(new_win | ~pwr_hit),
    .tick(tick)
  );

  // off wins a same-cycle rf clash, safer for the transmitter
  assign nxt_req.rf_on = (|rf_on_v) & ~(|rf_off_v);
  assign nxt_req.rf_off = |rf_off_v;
  assign nxt_req.sys_reset = |rst_v;
  assign nxt_req.ui_reboot = |boot_v;
  assign nxt_req.exc_sel = exc_hit;
  assign nxt_req.chg_flip = |chg_v;
  assign nxt_req.power_up = step & ~step_dn;
  assign nxt_req.power_dn = step & step_dn;
  assign nxt_req.preset_sel = pre_hit;

  assign nxt_exc_b = exc_hit ? (cfg_ff[exc_idx].arg == `RCI_EXC_B) : exc_b_ff;
  // several changeover inputs in one cycle still count as one activation
  assign nxt_chg = (|chg_v) ? ~chg_ff : chg_ff;
  assign nxt_preset = pre_hit ? cfg_ff[pre_idx].arg : preset_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      req_ff <= '0;
      exc_b_ff <= `RCI_EXC_SEL_RST;
      chg_ff <= `RCI_CHG_EN_RST;
      preset_ff <= `RCI_PRESET_RST;
    end else begin
      req_ff <= nxt_req;
      exc_b_ff <= nxt_exc_b;
      chg_ff <= nxt_chg;
      preset_ff <= nxt_preset;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwr_vld_ff <= 1'b0;
      pwr_idx_ff <= '0;
    end else begin
      pwr_vld_ff <= pwr_hit;
      pwr_idx_ff <= pwr_idx;
    end
  end

  // readback of pin level together with its settings
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stat_ff <= '0;
    end else if (rd_ok) begin
      stat_ff <= '{level: lvl[stat_rd_idx], cfg: cfg_ff[stat_rd_idx]};
    end else begin
      stat_ff <= '0;
    end
  end

  assign stat_rd_data = stat_ff;
  assign req = req_ff;
  assign exciter_sel_b = exc_b_ff;
  assign changeover_en = chg_ff;
  assign preset_sel = preset_ff;

endmodule

// >>> verification/rci_decoder_checker.sv
// Purpose: port-level assertions for the remote control input decoder
// Assumes: one clock, sync reset high
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
`include "rci_regs.svh"
module rci_decoder_checker import rci_pkg::*; #(
  parameter int unsigned STEP_CYC = 20
) (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // sync reset, high
  input wire logic [`RCI_NUM_IN-1:0] remote_in, // remote pins
  input wire logic remote_mode, // 1 remote
  input wire logic cfg_wr_en, // config strobe
  input wire logic [`RCI_IDX_W-1:0] cfg_wr_idx, // written input
  input wire rci_cfg_t cfg_wr_data, // written setting
  input wire logic [`RCI_IDX_W-1:0] stat_rd_idx, // reported input
  input wire rci_status_t stat_rd_data, // level and setting
  input wire rci_req_t req, // request pulses
  input wire logic exciter_sel_b, // exciter B main
  input wire logic changeover_en, // changeover on
  input wire logic [`RCI_ARG_W-1:0] preset_sel // chosen preset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // pins delayed to line up with the two-flop sync plus the status register
  logic [`RCI_NUM_IN-1:0] pin1_ff, pin2_ff, pin3_ff;
  always_ff @(posedge ref_clk) begin
    pin1_ff <= remote_in;
    pin2_ff <= pin1_ff;
    pin3_ff <= pin2_ff;
  end
  a_level_seen: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) && stat_rd_idx < 10 |=>
    stat_rd_data.level == pin3_ff[$past(stat_rd_idx)]) else $error("pin level not reported");
  sequence s_cfg_wr;
    cfg_wr_en && cfg_wr_idx < 10 && stat_rd_idx == cfg_wr_idx;
  endsequence
  sequence s_cfg_rd;
    !cfg_wr_en && $stable(stat_rd_idx);
  endsequence
  a_cfg_readback: assert property (
    s_cfg_wr ##1 s_cfg_rd |=> stat_rd_data.cfg == $past(cfg_wr_data, 2))
    else $error("setting not read back");
  a_local_quiet: assert property ((!remote_mode) [*5] |-> req == '0)
    else $error("request while local");
  a_local_hold: assert property ((!remote_mode) [*3] |=>
    $stable({exciter_sel_b, changeover_en, preset_sel})) else $error("state moved while local");
  a_rf_clash: assert property (!(req.rf_on && req.rf_off))
    else $error("rf on and off together");
  a_power_one: assert property (!(req.power_up && req.power_dn))
    else $error("power up and down together");
  a_step_gap: assert property (req.power_up |=> (!req.power_up) [*8])
    else $error("power steps too close");
  a_chg_cause: assert property ($changed(changeover_en) |->
    req.chg_flip || $past(req.chg_flip)) else $error("changeover moved alone");
  a_exc_cause: assert property ($changed(exciter_sel_b) |-> req.exc_sel)
    else $error("exciter moved alone");
  a_preset_cause: assert property ($changed(preset_sel) |-> req.preset_sel)
    else $error("preset moved alone");
  a_stat_range: assert property (stat_rd_idx >= 10 |=> stat_rd_data == '0)
    else $error("status of absent input");
  a_reset_quiet: assert property ($fell(sys_rst) |-> (req == '0) [*3])
    else $error("request right after reset");
endmodule

bind rci_decoder rci_decoder_checker #(.STEP_CYC(STEP_CYC)) rci_decoder_checker_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .remote_in(remote_in), .remote_mode(remote_mode),
  .cfg_wr_en(cfg_wr_en), .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data),
  .stat_rd_idx(stat_rd_idx), .stat_rd_data(stat_rd_data), .req(req),
  .exciter_sel_b(exciter_sel_b), .changeover_en(changeover_en), .preset_sel(preset_sel));

// >>> verification/rci_remote_unit.sv
// Purpose: model of the remote control unit driving the input pins
// Assumes: one pin change per command
// Notes: slow changes land one clock after the command, still on an edge
`timescale 1ns/1ps
module rci_remote_unit (
  input wire logic ref_clk, // system clock
  input wire logic set_en, // command strobe
  input wire logic [3:0] set_idx, // pin to change
  input wire logic set_val, // new pin level
  input wire logic set_slow, // late change, one clock after the strobe
  output logic [9:0] pins // remote pins, idle high
);
  logic [3:0] idx_ff = 4'h0;
  logic val_ff = 1'b0;
  logic late_ff = 1'b0;
  logic [9:0] pins_ff = 10'h3FF;
  // late changes still move on an edge, by non-blocking assignment
  always @(posedge ref_clk) begin
    late_ff <= set_en & set_slow;
    idx_ff <= set_idx;
    val_ff <= set_val;
    if (set_en && !set_slow) begin
      pins_ff[set_idx] <= set_val;
    end
    if (late_ff) begin
      pins_ff[idx_ff] <= val_ff;
    end
  end
  assign pins = pins_ff;
endmodule

// >>> verification/rci_decoder_tb_top.sv
// Purpose: self-checking bench for the remote control input decoder
// Assumes: STEP_CYC shortened to 20 cycles
// Notes: pins idle high; requests gathered over a window per pin change
`timescale 1ns/1ps
`include "rci_regs.svh"
module rci_decoder_tb_top import rci_pkg::*; ();
  logic ref_clk = 0, sys_rst = 1, remote_mode = 0, cfg_wr_en = 0;
  logic set_en = 0, set_val = 0, set_slow = 0;
  logic [3:0] cfg_wr_idx = 0, stat_rd_idx = 0, set_idx = 0, preset_sel;
  rci_cfg_t cfg_wr_data = '0;
  logic [`RCI_NUM_IN-1:0] remote_in;
  rci_status_t stat_rd_data;
  rci_req_t req, acc;
  logic exciter_sel_b, changeover_en;
  int err_total = 0, checked = 0, n_up, n_dn;
  logic [1:0] f_exp [12] = '{0, 2, 0, 1, 1, 0, 1, 2, 0, 2, 0, 2};
  logic [1:0] r_exp [12] = '{2, 0, 1, 0, 0, 2, 2, 1, 2, 0, 2, 0};
  logic [11:0] d_cfg [10] = '{12'h110, 12'h130, 12'h410, 12'h411, 12'h540, 12'h690,
    12'h6B0, 12'h010, 12'h010, 12'h010};
  rci_func_t fn [3] = '{RCI_FN_RESET, RCI_FN_REBOOT, RCI_FN_PRESET};
  logic [8:0] fx [3] = '{9'h040, 9'h020, 9'h001};
  always #2 ref_clk = ~ref_clk;
  rci_decoder #(.STEP_CYC(20)) rci_decoder_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .remote_in(remote_in), .remote_mode(remote_mode), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data), .stat_rd_idx(stat_rd_idx),
    .stat_rd_data(stat_rd_data), .req(req), .exciter_sel_b(exciter_sel_b),
    .changeover_en(changeover_en), .preset_sel(preset_sel));
  rci_remote_unit rci_remote_unit_inst (.ref_clk(ref_clk), .set_en(set_en),
    .set_idx(set_idx), .set_val(set_val), .set_slow(set_slow), .pins(remote_in));
  task automatic end_sim;
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic watch(input int n);
    acc = '0;
    n_up = 0;
    n_dn = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      acc = acc | req;
      n_up += req.power_up;
      n_dn += req.power_dn;
    end
  endtask
  // power bits masked: steps are counted separately
  task automatic pin(input int i, input logic v, input logic [8:0] e);
    @(posedge ref_clk);
    set_en <= 1'b1;
    set_idx <= 4'(i);
    set_val <= v;
    set_slow <= i[0];
    @(posedge ref_clk);
    set_en <= 1'b0;
    watch(12);
    cmp(16'(acc & 9'h1F9), 16'(e));
  endtask
  task automatic wr(input int i, input rci_cfg_t c);
    @(posedge ref_clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_idx <= 4'(i);
    cfg_wr_data <= c;
    @(posedge ref_clk);
    cfg_wr_en <= 1'b0;
  endtask
  task automatic rd(input int i, input logic [12:0] e);
    @(posedge ref_clk);
    stat_rd_idx <= 4'(i);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp(16'(stat_rd_data), 16'(e));
  endtask
  task automatic do_reset;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    do_reset();
    cmp(16'({exciter_sel_b, changeover_en, preset_sel}), 16'h0);
    for (int i = 0; i < 10; i++) rd(i, {1'b1, d_cfg[i]});
    wr(12, 12'h110);
    rd(12, 13'h0);
    pin(0, 0, 9'h0);
    pin(0, 1, 9'h0);
    pin(3, 0, 9'h0);
    pin(3, 1, 9'h0);
    cmp(16'(exciter_sel_b), 16'h0);
    @(posedge ref_clk) remote_mode <= 1'b1;
    pin(0, 0, 9'h100);
    pin(0, 1, 9'h0);
    pin(1, 0, 9'h080);
    pin(2, 0, 9'h010);
    cmp(16'(exciter_sel_b), 16'h0);
    pin(3, 0, 9'h010);
    cmp(16'(exciter_sel_b), 16'h1);
    pin(4, 0, 9'h0);
    pin(4, 1, 9'h0);
    pin(4, 0, 9'h008);
    cmp(16'(changeover_en), 16'h1);
    pin(7, 0, 9'h0);
    pin(7, 1, 9'h0);
    pin(5, 0, 9'h0);
    cmp(16'(n_up), 16'h1);
    watch(40);
    cmp(16'(n_up), 16'h2);
    pin(6, 0, 9'h0);
    cmp(16'(n_dn), 16'h0);
    pin(5, 1, 9'h0);
    cmp(16'(n_dn), 16'h1);
    pin(6, 1, 9'h0);
    watch(40);
    cmp(16'(n_up + n_dn), 16'h0);
    rd(9, {1'b1, 12'h010});
    for (int k = 0; k < 3; k++) begin
      wr(9, '{fn[k], RCI_MD_FALL_ON, 4'h3});
      pin(9, 0, fx[k]);
      pin(9, 1, 9'h0);
    end
    cmp(16'(preset_sel), 16'h3);
    rd(9, {1'b1, RCI_FN_PRESET, RCI_MD_FALL_ON, 4'h3});
    // leave the toggle armed so the reset below has something to clear
    pin(4, 1, 9'h0);
    pin(4, 0, 9'h0);
    for (int m = 0; m < 12; m++) begin
      do_reset();
      wr(8, '{RCI_FN_RF, rci_mode_t'(m), 4'h0});
      pin(8, 0, {f_exp[m], 7'h0});
      pin(8, 1, {r_exp[m], 7'h0});
    end
    // toggle state cleared by reset: first fall deactivates again
    pin(4, 1, 9'h0);
    pin(4, 0, 9'h0);
    cmp(16'(changeover_en), 16'h0);
    end_sim();
  end
  initial begin
    #20us;
    err_total++;
    end_sim();
  end
endmodule
